// [verilog/flash_ctrl_defs.vh]
// constants for the burst flash command controller
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH
// ----------------------------------------------------------------
// widths and timing
// ----------------------------------------------------------------
`define ADDR_W 20
`define DATA_W 32
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 8000
`define ACC_PROG_TIME_NS 2000
`define ERASE_WINDOW_NS 50000
`define SLEEP_TIME_NS 150
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES `NS_TO_CYC(`PROG_TIME_NS)
`define ACC_PROG_CYCLES `NS_TO_CYC(`ACC_PROG_TIME_NS)
`define SLEEP_CYCLES `NS_TO_CYC(`SLEEP_TIME_NS)
// ----------------------------------------------------------------
// command bytes and unlock addresses
// ----------------------------------------------------------------
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_CHIP_ERASE 8'h10
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define CMD_BYPASS_ENTER 8'h20
`define CMD_BYPASS_EXIT1 8'h90
`define CMD_BYPASS_EXIT2 8'h00
`define CMD_SECURE_ENTER 8'h88
`define CMD_SECURE_EXIT 8'h90
`define CMD_PASSWORD 8'h38
`define UNLOCK_ADDR1 11'h555
`define UNLOCK_ADDR2 11'h2AA
// ----------------------------------------------------------------
// array geometry in word addresses, burst lengths, erased value and status bit positions
// ----------------------------------------------------------------
`define SECTORS 46
`define LOW_SMALL_END 20'h0_8000
`define HIGH_SMALL_BASE 20'hF_8000
`define BANK_SPLIT 20'h4_0000
`define SMALL_SPAN 20'h0_0FFF
`define LARGE_SPAN 20'h0_7FFF
`define WP_SECTORS 46'h3000_0000_0000
`define SEC_WORDS 128
`define BURST_X16_LAST 3'h7
`define BURST_X32_LAST 3'h3
`define ERASED_WORD 16'hFFFF
`define POLL_BIT 7
`define TOGGLE_BIT 6
`endif

// [verilog/pin_sync.v]
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 8,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;
  always @(posedge clk) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// [verilog/burst_flash_command_control.v]
// command sequencer, array and read path of the dual-bank burst flash
`timescale 1ns/1ps
`include "flash_ctrl_defs.vh"
module burst_flash_command_control #(
  parameter ERASE_WINDOW_CYCLES = `NS_TO_CYC(`ERASE_WINDOW_NS)
) (
  input wire clk,
  input wire rst_n,
  input wire ce_n,
  input wire we_n,
  input wire oe_n,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] data_in,
  input wire burst_clk,
  input wire burst_address_load_n,
  input wire reset_pin_n,
  input wire write_protect_n,
  input wire program_accelerate_in,
  input wire bus_x32,
  input wire [`SECTORS-1:0] sector_protect_mask,
  input wire [63:0] user_password,
  input wire select_password_mode,
  input wire secured_lock_set,
  output reg [`DATA_W-1:0] data_out,
  output reg data_oe,
  output reg ready_busy_out,
  output reg sleep_active,
  output reg password_mode,
  output reg password_unlocked,
  output reg secured_locked,
  output reg secured_mode,
  output reg erase_suspended
);
  // ----------------------------------------------------------------
  // states and constants
  // ----------------------------------------------------------------
  localparam [3:0] C_IDLE = 4'h0, C_UNLK1 = 4'h1, C_UNLK2 = 4'h2, C_PROG = 4'h3, C_ERS1 = 4'h4,
    C_ERS2 = 4'h5, C_ERS3 = 4'h6, C_ERSW = 4'h7, C_BYP = 4'h8, C_BYPP = 4'h9, C_BYPX = 4'hA,
    C_PWD = 4'hB;
  localparam [2:0] O_IDLE = 3'h0, O_PROG = 3'h1, O_ERASE = 3'h2, O_ESUSP = 3'h3, O_PSUSP = 3'h4;
  localparam [15:0] PROG_CYC = `PROG_CYCLES;
  localparam [15:0] ACC_CYC = `ACC_PROG_CYCLES;
  localparam [15:0] WIN_CYC = ERASE_WINDOW_CYCLES;
  localparam [15:0] SLEEP_CYC = `SLEEP_CYCLES;
  localparam [`ADDR_W-1:0] SEC_LAST = `SEC_WORDS - 1;

  // ----------------------------------------------------------------
  // sector and bank decoding
  // ----------------------------------------------------------------
  function [5:0] sector_of;
    input [`ADDR_W-1:0] a;
    begin
      if (a < `LOW_SMALL_END) begin
        sector_of = {3'h0, a[14:12]};
      end else if (a < `HIGH_SMALL_BASE) begin
        sector_of = 6'h07 + {1'b0, a[19:15]};
      end else begin
        sector_of = 6'h26 + {3'h0, a[14:12]};
      end
    end
  endfunction

  function [`ADDR_W-1:0] span_of;
    input [`ADDR_W-1:0] a;
    begin
      span_of = (a < `LOW_SMALL_END || a >= `HIGH_SMALL_BASE) ? `SMALL_SPAN : `LARGE_SPAN;
    end
  endfunction

  function bank_of;
    input [`ADDR_W-1:0] a;
    begin
      bank_of = (a >= `BANK_SPLIT);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  wire [59:0] pin_q;
  pin_sync #(.W(60), .RESET_VAL({8'hEE, 52'h0_0000_0000_0000})) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({ce_n, we_n, oe_n, burst_clk, burst_address_load_n, reset_pin_n, write_protect_n,
        program_accelerate_in, addr, data_in}),
    .q(pin_q)
  );
  wire ce_s = pin_q[59];
  wire we_s = pin_q[58];
  wire oe_s = pin_q[57];
  wire bclk_s = pin_q[56];
  wire adv_s = pin_q[55];
  wire rstpin_s = pin_q[54];
  wire wp_s = pin_q[53];
  wire acc_s = pin_q[52];
  wire [`ADDR_W-1:0] addr_s = pin_q[51:32];
  wire [`DATA_W-1:0] data_s = pin_q[31:0];
  reg we_d;
  reg oe_d;
  reg bclk_d;
  wire wr_evt = ~we_d & we_s & ~ce_s;
  wire rd_start = oe_d & ~oe_s & ~ce_s;
  wire bclk_rise = ~bclk_d & bclk_s;
  wire [7:0] d8 = data_s[7:0];
  wire unlock1_hit = (d8 == `CMD_UNLOCK1) && (addr_s[10:0] == `UNLOCK_ADDR1);
  wire unlock2_hit = (d8 == `CMD_UNLOCK2) && (addr_s[10:0] == `UNLOCK_ADDR2);
  wire [`ADDR_W-1:0] cur_wa = bus_x32 ? {addr_s[18:0], 1'b0} : addr_s;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [15:0] mem [0:(1 << `ADDR_W) - 1];
  reg [15:0] sec_mem [0:`SEC_WORDS-1];
  reg [3:0] cst;
  reg [2:0] op;
  reg op_sec;
  reg op_x32;
  reg op_ret_esusp;
  reg [`ADDR_W-1:0] op_addr;
  reg [`DATA_W-1:0] op_data;
  reg [15:0] op_cnt;
  reg [15:0] win_cnt;
  reg [`SECTORS-1:0] erase_sel;
  reg [`SECTORS-1:0] pend_sel;
  reg [47:0] pwd_buf;
  reg [1:0] pwd_idx;
  reg toggle_status_bit;
  reg burst_active;
  reg [`ADDR_W-1:0] burst_wa;
  reg [2:0] burst_beat;
  reg [`ADDR_W-1:0] addr_prev;
  reg [15:0] sleep_cnt;
  integer k;

  initial begin
    for (k = 0; k < (1 << `ADDR_W); k = k + 1) begin
      mem[k] = `ERASED_WORD;
    end
    for (k = 0; k < `SEC_WORDS; k = k + 1) begin
      sec_mem[k] = `ERASED_WORD;
    end
  end

  // protection: mask applies unless password mode is unlocked; write protect always
  wire [`SECTORS-1:0] blocked_vec = (sector_protect_mask & {`SECTORS{~(password_mode & password_unlocked)}}) |
    (`WP_SECTORS & {`SECTORS{~wp_s}});
  wire running = (op == O_PROG) || (op == O_ERASE);
  wire erase_sel_hit = erase_sel[sector_of(op_addr)];
  wire [20:0] erase_next = erase_sel_hit ? {1'b0, op_addr} + 21'h00_0001 :
    {1'b0, op_addr | span_of(op_addr)} + 21'h00_0001;
  wire op_done = ((op == O_PROG) && (op_cnt == 16'h0001)) ||
    ((op == O_ERASE) && (op_sec ? (op_addr == SEC_LAST) : erase_next[20]));

  // ----------------------------------------------------------------
  // operation launch helpers
  // ----------------------------------------------------------------
  task start_program;
    input [`ADDR_W-1:0] wa;
    input [`DATA_W-1:0] d;
    reg [5:0] s;
    begin
      s = sector_of(wa);
      op_addr <= wa;
      op_data <= d;
      op_x32 <= bus_x32;
      op_cnt <= acc_s ? ACC_CYC : PROG_CYC;
      if (secured_mode && wa < `SEC_WORDS) begin
        if (!secured_locked) begin
          op <= O_PROG;
          op_sec <= 1'b1;
        end
      end else if (!blocked_vec[s] && !((op == O_ESUSP) && erase_sel[s])) begin
        op <= O_PROG;
        op_sec <= 1'b0;
        op_ret_esusp <= (op == O_ESUSP);
      end
    end
  endtask

  task start_erase;
    input [`SECTORS-1:0] sel;
    begin
      op_addr <= {`ADDR_W{1'b0}};
      if (secured_mode) begin
        if (!secured_locked) begin
          op <= O_ERASE;
          op_sec <= 1'b1;
        end
      end else if (|sel) begin
        op <= O_ERASE;
        op_sec <= 1'b0;
        erase_sel <= sel;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // command sequencer and embedded operations
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      cst <= C_IDLE;
      op <= O_IDLE;
      op_sec <= 1'b0;
      op_x32 <= 1'b0;
      op_ret_esusp <= 1'b0;
      op_addr <= {`ADDR_W{1'b0}};
      op_data <= {`DATA_W{1'b0}};
      op_cnt <= 16'h0000;
      win_cnt <= 16'h0000;
      erase_sel <= {`SECTORS{1'b0}};
      pend_sel <= {`SECTORS{1'b0}};
      pwd_buf <= 48'h0000_0000_0000;
      pwd_idx <= 2'h0;
      password_mode <= 1'b0;
      password_unlocked <= 1'b0;
      secured_locked <= 1'b0;
      secured_mode <= 1'b0;
    end else if (!rstpin_s) begin
      cst <= C_IDLE;
      op <= O_IDLE;
      op_ret_esusp <= 1'b0;
      erase_sel <= {`SECTORS{1'b0}};
      password_unlocked <= 1'b0;
      secured_mode <= 1'b0;
    end else begin
      if (select_password_mode) begin
        password_mode <= 1'b1;
      end
      if (secured_lock_set) begin
        secured_locked <= 1'b1;
      end
      // embedded program and erase progress
      if (op == O_PROG) begin
        op_cnt <= op_cnt - 16'h0001;
        if (op_done) begin
          if (op_sec) begin
            sec_mem[op_addr[6:0]] <= sec_mem[op_addr[6:0]] & op_data[15:0];
          end else begin
            mem[op_addr] <= mem[op_addr] & op_data[15:0];
            if (op_x32) begin
              mem[{op_addr[19:1], 1'b1}] <= mem[{op_addr[19:1], 1'b1}] & op_data[31:16];
            end
          end
          op <= op_ret_esusp ? O_ESUSP : O_IDLE;
          if (op_ret_esusp) begin
            op_addr <= {`ADDR_W{1'b0}}; // pointer was reused, erase walk restarts from the bottom
          end
          op_ret_esusp <= 1'b0;
        end
      end else if (op == O_ERASE) begin
        if (op_sec) begin
          sec_mem[op_addr[6:0]] <= `ERASED_WORD;
          op_addr <= op_addr + 20'h0_0001;
        end else begin
          if (erase_sel_hit) begin
            mem[op_addr] <= `ERASED_WORD;
          end
          op_addr <= erase_next[19:0];
        end
        if (op_done) begin
          op <= O_IDLE;
          erase_sel <= {`SECTORS{1'b0}};
        end
      end
      // host write cycles
      if (wr_evt) begin
        if (running) begin
          if (d8 == `CMD_SUSPEND && !op_done && !op_ret_esusp) begin
            op <= (op == O_ERASE) ? O_ESUSP : O_PSUSP;
          end
        end else if (op == O_PSUSP || (op == O_ESUSP && cst == C_IDLE && d8 == `CMD_RESUME)) begin
          if (d8 == `CMD_RESUME) begin
            op <= (op == O_ESUSP) ? O_ERASE : O_PROG;
          end
        end else begin
          case (cst)
            C_IDLE: begin
              cst <= unlock1_hit ? C_UNLK1 : C_IDLE;
            end
            C_UNLK1: begin
              cst <= unlock2_hit ? C_UNLK2 : C_IDLE;
            end
            C_UNLK2: begin
              cst <= C_IDLE;
              case (d8)
                `CMD_PROGRAM: cst <= C_PROG;
                `CMD_ERASE_SETUP: cst <= (op == O_IDLE) ? C_ERS1 : C_IDLE;
                `CMD_BYPASS_ENTER: cst <= C_BYP;
                `CMD_SECURE_ENTER: secured_mode <= 1'b1;
                `CMD_SECURE_EXIT: secured_mode <= 1'b0;
                `CMD_PASSWORD: begin
                  cst <= C_PWD;
                  pwd_idx <= 2'h0;
                end
                default: cst <= C_IDLE;
              endcase
            end
            C_PROG: begin
              start_program(cur_wa, data_s);
              cst <= C_IDLE;
            end
            C_ERS1: begin
              cst <= unlock1_hit ? C_ERS2 : C_IDLE;
            end
            C_ERS2: begin
              cst <= unlock2_hit ? C_ERS3 : C_IDLE;
            end
            C_ERS3: begin
              cst <= C_IDLE;
              if (d8 == `CMD_CHIP_ERASE) begin
                start_erase(~blocked_vec);
              end else if (d8 == `CMD_SECTOR_ERASE) begin
                pend_sel <= ({{(`SECTORS-1){1'b0}}, 1'b1} << sector_of(cur_wa)) & ~blocked_vec;
                win_cnt <= WIN_CYC;
                cst <= C_ERSW;
              end
            end
            C_ERSW: begin
              if (d8 == `CMD_SECTOR_ERASE) begin
                pend_sel <= pend_sel | (({{(`SECTORS-1){1'b0}}, 1'b1} << sector_of(cur_wa)) & ~blocked_vec);
                win_cnt <= WIN_CYC;
              end else begin
                cst <= C_IDLE;
              end
            end
            C_BYP: begin
              if (d8 == `CMD_PROGRAM) begin
                cst <= C_BYPP;
              end else if (d8 == `CMD_BYPASS_EXIT1) begin
                cst <= C_BYPX;
              end
            end
            C_BYPP: begin
              start_program(cur_wa, data_s);
              cst <= C_BYP;
            end
            C_BYPX: begin
              cst <= (d8 == `CMD_BYPASS_EXIT2) ? C_IDLE : C_BYP;
            end
            C_PWD: begin
              pwd_buf <= {pwd_buf[31:0], data_s[15:0]};
              pwd_idx <= pwd_idx + 2'h1;
              if (pwd_idx == 2'h3) begin
                password_unlocked <= ({pwd_buf, data_s[15:0]} == user_password);
                cst <= C_IDLE;
              end
            end
            default: cst <= C_IDLE;
          endcase
        end
      end else if (cst == C_ERSW) begin
        if (win_cnt <= 16'h0001) begin
          start_erase(pend_sel);
          cst <= C_IDLE;
        end else begin
          win_cnt <= win_cnt - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read path, burst sequencing, status and sleep
  // ----------------------------------------------------------------
  wire [`ADDR_W-1:0] rd_wa = burst_active ? burst_wa : cur_wa;
  wire [`ADDR_W-1:0] rd_wa_hi = {rd_wa[19:1], 1'b1};
  wire status_hit = (running && bank_of(rd_wa) == bank_of(op_addr)) ||
    (op == O_ESUSP && erase_sel[sector_of(rd_wa)]);
  wire rd_secured = secured_mode && (rd_wa < `SEC_WORDS);
  reg [`DATA_W-1:0] next_data_out;

  always @* begin
    next_data_out = {`DATA_W{1'b0}};
    if (status_hit) begin
      next_data_out[`POLL_BIT] = (op == O_PROG) ? ~op_data[`POLL_BIT] : 1'b0;
      next_data_out[`TOGGLE_BIT] = toggle_status_bit;
    end else if (rd_secured) begin
      next_data_out[15:0] = sec_mem[rd_wa[6:0]];
      if (bus_x32) begin
        next_data_out[31:16] = sec_mem[rd_wa_hi[6:0]];
      end
    end else begin
      next_data_out[15:0] = mem[rd_wa];
      if (bus_x32) begin
        next_data_out[31:16] = mem[rd_wa_hi];
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      we_d <= 1'b1;
      oe_d <= 1'b1;
      bclk_d <= 1'b0;
      data_out <= {`DATA_W{1'b0}};
      data_oe <= 1'b0;
      ready_busy_out <= 1'b1;
      sleep_active <= 1'b0;
      erase_suspended <= 1'b0;
      toggle_status_bit <= 1'b0;
      burst_active <= 1'b0;
      burst_wa <= {`ADDR_W{1'b0}};
      burst_beat <= 3'h0;
      addr_prev <= {`ADDR_W{1'b0}};
      sleep_cnt <= 16'h0000;
    end else begin
      we_d <= we_s;
      oe_d <= oe_s;
      bclk_d <= bclk_s;
      data_out <= next_data_out;
      data_oe <= ~ce_s & ~oe_s & we_s;
      ready_busy_out <= ~running;
      erase_suspended <= (op == O_ESUSP);
      if (rd_start && status_hit && running) begin
        toggle_status_bit <= ~toggle_status_bit;
      end
      if (!rstpin_s || ce_s) begin
        burst_active <= 1'b0;
      end else if (bclk_rise) begin
        if (!adv_s) begin
          burst_active <= 1'b1;
          burst_wa <= cur_wa;
          burst_beat <= 3'h0;
        end else if (burst_active) begin
          if (burst_beat == (bus_x32 ? `BURST_X32_LAST : `BURST_X16_LAST)) begin
            burst_active <= 1'b0;
          end else begin
            burst_beat <= burst_beat + 3'h1;
            burst_wa <= bus_x32 ? {burst_wa[19:3], burst_wa[2:1] + 2'h1, 1'b0} :
              {burst_wa[19:3], burst_wa[2:0] + 3'h1};
          end
        end
      end
      addr_prev <= addr_s;
      if (addr_s != addr_prev) begin
        sleep_cnt <= 16'h0000;
        sleep_active <= 1'b0;
      end else if (sleep_cnt < SLEEP_CYC) begin
        sleep_cnt <= sleep_cnt + 16'h0001;
      end else begin
        sleep_active <= 1'b1;
      end
    end
  end
endmodule

// [verification/flash_cmd_chk.sv]
// assertions on the pins of the burst flash command controller
`timescale 1ns/1ps
`include "flash_ctrl_defs.vh"
module flash_cmd_chk (
  input wire clk,
  input wire rst_n,
  input wire ce_n,
  input wire we_n,
  input wire oe_n,
  input wire [`ADDR_W-1:0] addr,
  input wire reset_pin_n,
  input wire bus_x32,
  input wire select_password_mode,
  input wire [`DATA_W-1:0] data_out,
  input wire data_oe,
  input wire ready_busy_out,
  input wire sleep_active,
  input wire password_mode,
  input wire secured_locked
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // address stability counter
  // ----------------------------------------
  logic [4:0] stable_cnt;
  always @(posedge clk) begin
    if (!rst_n || addr != $past(addr)) begin
      stable_cnt <= 5'h00;
    end else if (stable_cnt != 5'h1f) begin
      stable_cnt <= stable_cnt + 5'h01;
    end
  end
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence s_read_pins;
    (!ce_n && !oe_n && we_n) [*4];
  endsequence
  sequence s_pin_reset;
    (!reset_pin_n) [*6];
  endsequence
  sequence s_narrow;
    (!bus_x32) [*3];
  endsequence
  a_read_enable: assert property (s_read_pins |-> data_oe)
    else $error("output enable missing on read");
  a_pin_abort: assert property (s_pin_reset |-> ready_busy_out)
    else $error("reset pin did not end the operation");
  a_sleep_entry: assert property (stable_cnt == 5'h18 |-> sleep_active)
    else $error("no sleep after stable address");
  a_sleep_wake: assert property ($changed(addr) |-> ##[1:5] !sleep_active)
    else $error("sleep kept after address change");
  a_mode_sticky: assert property (password_mode |=> password_mode)
    else $error("password mode dropped");
  a_mode_cause: assert property ($rose(password_mode) |->
    ($past(select_password_mode) || $past(select_password_mode, 2)))
    else $error("password mode set without request");
  a_lock_sticky: assert property (secured_locked |=> secured_locked)
    else $error("secured lock dropped");
  a_narrow_upper: assert property (s_narrow |-> data_out[31:16] == 16'h0000)
    else $error("upper half driven in narrow mode");
endmodule
bind burst_flash_command_control flash_cmd_chk chk (.clk(clk), .rst_n(rst_n), .ce_n(ce_n), .we_n(we_n),
  .oe_n(oe_n), .addr(addr), .reset_pin_n(reset_pin_n), .bus_x32(bus_x32),
  .select_password_mode(select_password_mode), .data_out(data_out), .data_oe(data_oe),
  .ready_busy_out(ready_busy_out), .sleep_active(sleep_active), .password_mode(password_mode),
  .secured_locked(secured_locked));

// [verification/host_bus_model.sv]
// host processor bus model for the flash controller
`timescale 1ns/1ps
`include "flash_ctrl_defs.vh"
module host_bus_model (
  input wire clk,
  input wire [`DATA_W-1:0] data_out,
  output logic ce_n = 1'b1,
  output logic we_n = 1'b1,
  output logic oe_n = 1'b1,
  output logic [`ADDR_W-1:0] addr = 20'h0_0000,
  output logic [`DATA_W-1:0] data_in = 32'h0000_0000,
  output logic burst_clk = 1'b0,
  output logic burst_address_load_n = 1'b1
);
  localparam logic [19:0] u1 = {9'h000, `UNLOCK_ADDR1};
  localparam logic [19:0] u2 = {9'h000, `UNLOCK_ADDR2};
  logic [31:0] bq[$];
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // strobe long enough to pass the synchroniser, address and data held
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    data_in <= {16'h0000, d};
    ce_n <= 1'b0;
    we_n <= 1'b0;
    hold(4);
    we_n <= 1'b1;
    hold(4);
    ce_n <= 1'b1;
    data_in <= ~data_in;
    hold(2); // launched operation reaches the ready pin before the caller looks
  endtask
  task automatic unlock(input logic [7:0] c);
    wr(u1, {8'h00, `CMD_UNLOCK1});
    wr(u2, {8'h00, `CMD_UNLOCK2});
    wr(u1, {8'h00, c});
  endtask
  task automatic program_word(input logic [19:0] a, input logic [15:0] d);
    unlock(`CMD_PROGRAM);
    wr(a, d);
  endtask
  task automatic bypass_word(input logic [19:0] a, input logic [15:0] d);
    wr(a, {8'h00, `CMD_PROGRAM});
    wr(a, d);
  endtask
  task automatic erase_sector(input logic [19:0] a);
    unlock(`CMD_ERASE_SETUP);
    wr(u1, {8'h00, `CMD_UNLOCK1});
    wr(u2, {8'h00, `CMD_UNLOCK2});
    wr(a, {8'h00, `CMD_SECTOR_ERASE});
  endtask
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    hold(5);
    #1 d = data_out;
    oe_n <= 1'b1;
    ce_n <= 1'b1;
    hold(2);
  endtask
  // link clock runs only inside the burst
  task automatic burst(input logic [19:0] a, input int beats);
    @(posedge clk);
    addr <= a;
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    burst_address_load_n <= 1'b0;
    for (int i = 0; i < beats; i++) begin
      hold(8);
      burst_clk <= 1'b1;
      hold(8);
      #1 bq.push_back(data_out);
      burst_clk <= 1'b0;
      burst_address_load_n <= 1'b1;
      addr <= ~addr;
    end
    ce_n <= 1'b1;
    oe_n <= 1'b1;
  endtask
endmodule

// [verification/tb_burst_flash_command_control.sv]
// self-checking bench for the burst flash command controller
`timescale 1ns/1ps
`include "flash_ctrl_defs.vh"
module tb_burst_flash_command_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic write_protect_n = 1'b1;
  logic acc = 1'b0;
  logic bus_x32 = 1'b0;
  logic [45:0] mask = 46'h0;
  logic [63:0] pw = 64'h0;
  logic sel_pw = 1'b0;
  logic lock_set = 1'b0;
  wire ce_n, we_n, oe_n, burst_clk, load_n, data_oe, ready, sleep, pw_mode, locked, unlocked, esusp;
  wire [19:0] addr;
  wire [31:0] data_in, data_out;
  logic [31:0] exp_q[$];
  logic [31:0] seen;
  logic seen_v = 1'b0;
  logic [31:0] v;
  logic [31:0] v2;
  logic [15:0] wd[8];
  logic [15:0] wo;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  burst_flash_command_control #(.ERASE_WINDOW_CYCLES(20)) uut (.clk(clk), .rst_n(rst_n), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .addr(addr), .data_in(data_in), .burst_clk(burst_clk),
    .burst_address_load_n(load_n), .reset_pin_n(reset_pin_n), .write_protect_n(write_protect_n),
    .program_accelerate_in(acc), .bus_x32(bus_x32), .sector_protect_mask(mask), .user_password(pw),
    .select_password_mode(sel_pw), .secured_lock_set(lock_set), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_out(ready), .sleep_active(sleep), .password_mode(pw_mode), .password_unlocked(unlocked),
    .secured_locked(locked), .secured_mode(), .erase_suspended(esusp));
  host_bus_model host (.clk(clk), .data_out(data_out), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .addr(addr), .data_in(data_in), .burst_clk(burst_clk), .burst_address_load_n(load_n));
  // ----------------------------------------
  // expectation queue and result monitor
  // ----------------------------------------
  task automatic note(input logic [31:0] e, input logic [31:0] a);
    exp_q.push_back(e);
    seen <= a;
    seen_v <= 1'b1;
    @(posedge clk);
    seen_v <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (seen_v) begin
      checked++;
      if (seen !== exp_q[0]) begin
        fail_count++;
        $display("FAIL %0t: got %h expected %h", $time, seen, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    if (cycles == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_ready(input int n);
    int k;
    k = 0;
    while (ready !== 1'b1 && k < n) begin
      @(posedge clk);
      k++;
    end
    note(32'h1, {31'h0, ready});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(31));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    pw <= {$urandom, $urandom};
    repeat (3) @(posedge clk);
    note(32'h1, {31'h0, ready});
    note(32'h0, {31'h0, pw_mode});
    for (int i = 0; i < 8; i++) wd[i] = 16'($urandom);
    wo = 16'($urandom);
    acc <= 1'b1;
    host.program_word(20'h0_1000, wd[0]);
    note(32'h0, {31'h0, ready});
    host.rd(20'h0_1000, v);
    host.rd(20'h0_1000, v2);
    note({31'h0, ~wd[0][`POLL_BIT]}, {31'h0, v[`POLL_BIT]});
    note(32'h1, {31'h0, v[`TOGGLE_BIT] ^ v2[`TOGGLE_BIT]});
    host.rd(20'h5_0000, v);
    note(32'h0000_ffff, v);
    wait_ready(400);
    acc <= 1'b0;
    host.unlock(`CMD_BYPASS_ENTER);
    for (int i = 1; i < 9; i++) begin
      host.bypass_word(i == 8 ? 20'h0_0010 : 20'h0_1000 + i, i == 8 ? wo : wd[i]);
      wait_ready(1000);
    end
    host.wr(20'h0_0000, {8'h00, `CMD_BYPASS_EXIT1});
    host.wr(20'h0_0000, {8'h00, `CMD_BYPASS_EXIT2});
    for (int i = 0; i < 8; i++) begin
      host.rd(20'h0_1000 + i, v);
      note({16'h0000, wd[i]}, v);
    end
    bus_x32 <= 1'b1;
    host.rd(20'h0_0800, v);
    note({wd[1], wd[0]}, v);
    bus_x32 <= 1'b0;
    host.burst(20'h0_1005, 8);
    for (int i = 0; i < 8; i++) note({16'h0000, wd[(5 + i) % 8]}, host.bq.pop_front());
    repeat (30) @(posedge clk);
    note(32'h1, {31'h0, sleep});
    mask <= 46'h2;
    host.program_word(20'h0_1008, 16'h0000);
    note(32'h1, {31'h0, ready});
    host.rd(20'h0_1008, v);
    note(32'h0000_ffff, v);
    mask <= 46'h0;
    write_protect_n <= 1'b0;
    sel_pw <= 1'b1;
    @(posedge clk);
    sel_pw <= 1'b0;
    host.program_word(20'h0_f000 | 20'hf_0000, 16'h0000);
    host.rd(20'hf_f000, v);
    note(32'h0000_ffff, v);
    note(32'h1, {31'h0, pw_mode});
    write_protect_n <= 1'b1;
    mask <= 46'h4;
    host.unlock(`CMD_PASSWORD);
    for (int i = 3; i >= 0; i--) host.wr(20'h0_0000, pw[16*i +: 16]);
    note(32'h1, {31'h0, unlocked});
    host.program_word(20'h0_2000, 16'h0000);
    repeat (50) @(posedge clk);
    note(32'h0, {31'h0, ready});
    reset_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    note(32'h1, {31'h0, ready});
    reset_pin_n <= 1'b1;
    host.rd(20'h0_2000, v);
    note(32'h0000_ffff, v);
    host.erase_sector(20'h0_1000);
    repeat (25) @(posedge clk);
    note(32'h0, {31'h0, ready});
    host.wr(20'h0_0000, {8'h00, `CMD_SUSPEND});
    note(32'h1, {31'h0, esusp});
    host.program_word(20'h0_0011, wd[1]);
    wait_ready(1000);
    host.rd(20'h0_0011, v);
    note({16'h0000, wd[1]}, v);
    host.wr(20'h0_0000, {8'h00, `CMD_RESUME});
    wait_ready(12000);
    host.rd(20'h0_1003, v);
    note(32'h0000_ffff, v);
    host.rd(20'h0_0010, v);
    note({16'h0000, wo}, v);
    lock_set <= 1'b1;
    @(posedge clk);
    lock_set <= 1'b0;
    repeat (2) @(posedge clk);
    note(32'h1, {31'h0, locked});
    report_and_stop();
  end
endmodule
